// ### rtl/ubm_uart.sv
// Purpose: UART transceiver with fractional divisor, TX-active and modem lines
// Assumes: Inputs synchronous to core_clk; register port strobes one cycle
// Notes: One holding register each way; divisor clamps into 4..40000
// ==========================================
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ubm_uart (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // Straps
    input wire logic interface_cfg_pin0,
    input wire logic interface_cfg_pin1,
    // Serial and modem pins
    input wire logic rxd,
    output logic txd,
    output logic tx_active,
    output logic receive_ready_n,
    input wire logic peer_ready_n,
    output logic terminal_ready_n,
    input wire logic peer_set_ready_n,
    input wire logic carrier_detect,
    input wire logic ring_indicate
);
    import ubm_pkg::*;

    // ==========================================
    // Registers
    logic [8:0] ctrl, next_ctrl;
    logic [18:0] baud, next_baud;
    logic [UBM_IRQ_W-1:0] irq_st, next_irq_st, irq_mask, next_irq_mask;
    logic [7:0] tx_hold, next_tx_hold, rx_hold, next_rx_hold;
    logic tx_full, next_tx_full, rx_full, next_rx_full;
    logic [31:0] next_rdata;
    logic uart_on, next_uart_on, cfg_done, next_cfg_done, ring_q, next_ring_q;
    logic [15:0] wr_int;

    // Clamp an integer divisor into the legal window
    function automatic logic [15:0] clamp_div(input logic [15:0] v);
        if (v < UBM_DIV_MIN) clamp_div = UBM_DIV_MIN;
        else if (v > UBM_DIV_MAX) clamp_div = UBM_DIV_MAX;
        else clamp_div = v;
    endfunction : clamp_div

    // Transmit and receive state
    ubm_state_e ts, next_ts, rs, next_rs;
    logic [7:0] tsh, next_tsh, rsh, next_rsh;
    logic [2:0] tcnt, next_tcnt, rcnt, next_rcnt;
    logic tbit, next_tbit, tact, next_tact;
    logic rpar, next_rpar;
    logic [7:0] tframe, next_tframe;
    logic tx_done, rx_done, rx_perr;
    logic tx_allowed, rx_busy;

    ubm_tick_if ttk ();
    ubm_tick_if rtk ();
    ubm_baud_gen u_tx_baud (
        .core_clk(core_clk), .rst(rst),
        .div_int(baud[18:3]), .div_frac(baud[2:0]), .tk(ttk.gen)
    );
    ubm_baud_gen u_rx_baud (
        .core_clk(core_clk), .rst(rst),
        .div_int(baud[18:3]), .div_frac(baud[2:0]), .tk(rtk.gen)
    );

    logic bits8, stop2, par_on;
    logic [2:0] par_mode;
    logic [1:0] flow;
    assign bits8 = ctrl[UBM_CTRL_BITS8];
    assign stop2 = ctrl[UBM_CTRL_STOP2];
    assign par_mode = ctrl[UBM_CTRL_PAR_LSB+2:UBM_CTRL_PAR_LSB];
    assign par_on = (par_mode != UBM_PAR_NONE);
    assign flow = ctrl[UBM_CTRL_FLOW_LSB+1:UBM_CTRL_FLOW_LSB];

    // ==========================================
    // Register port
    always_comb begin
        next_ctrl = ctrl;
        next_baud = baud;
        next_irq_mask = irq_mask;
        next_tx_hold = tx_hold;
        next_cfg_done = cfg_done;
        next_rdata = 32'h00000000;
        wr_int = clamp_div(reg_wdata[18:3]);
        next_irq_st = irq_st;
        if (reg_wr && reg_addr == UBM_REG_IRQ) next_irq_st = irq_st & ~reg_wdata[UBM_IRQ_W-1:0];
        // Set beats a same-cycle clear
        if (tx_done) next_irq_st[UBM_IRQ_TXDONE] = 1'b1;
        if (rx_done) next_irq_st[UBM_IRQ_RXFULL] = 1'b1;
        if (rx_perr) next_irq_st[UBM_IRQ_PERR] = 1'b1;
        if (ring_indicate && !ring_q) next_irq_st[UBM_IRQ_RING] = 1'b1;
        if (reg_wr) begin
            unique case (reg_addr)
                UBM_REG_CTRL: next_ctrl = reg_wdata[8:0];
                UBM_REG_BAUD: begin
                    // Low bits are eighths; finer fractions truncate downward
                    next_baud = {wr_int, reg_wdata[2:0]};
                    next_cfg_done = 1'b1;
                end
                UBM_REG_MASK: next_irq_mask = reg_wdata[UBM_IRQ_W-1:0];
                UBM_REG_TXD: next_tx_hold = reg_wdata[7:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                UBM_REG_CTRL: next_rdata = {23'h000000, ctrl};
                UBM_REG_BAUD: next_rdata = {13'h0000, baud};
                UBM_REG_STAT: next_rdata = {24'h000000, uart_on, tact, carrier_detect,
                                            ring_indicate, peer_set_ready_n, peer_ready_n,
                                            rx_full, tx_full};
                UBM_REG_RXD: next_rdata = {24'h000000, rx_hold};
                UBM_REG_IRQ: next_rdata = {28'h0000000, irq_st};
                UBM_REG_MASK: next_rdata = {28'h0000000, irq_mask};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end
    assign irq = |(irq_st & irq_mask);

    // ==========================================
    // Holding flags
    always_comb begin
        next_tx_full = tx_full;
        next_rx_full = rx_full;
        next_rx_hold = rx_hold;
        if (ts == UBM_S_IDLE && tx_full && tx_allowed) next_tx_full = 1'b0;
        if (reg_wr && reg_addr == UBM_REG_TXD) next_tx_full = 1'b1;
        if (reg_rd && reg_addr == UBM_REG_RXD) next_rx_full = 1'b0;
        // Arrival beats a same-cycle read of the holding register
        if (rx_done && (!rx_full || (reg_rd && reg_addr == UBM_REG_RXD))) begin
            next_rx_full = 1'b1;
            next_rx_hold = bits8 ? rsh : {1'b0, rsh[7:1]};
        end
    end

    // Straps: 1x enables the serial port; pin1 is resampled every cycle
    assign next_uart_on = interface_cfg_pin1;
    assign next_ring_q = ring_indicate;

    // ==========================================
    // Transmitter
    assign tx_allowed = uart_on && cfg_done && ctrl[UBM_CTRL_EN]
        && !(flow == UBM_FLOW_RTSCTS && peer_ready_n)
        && !(flow == UBM_FLOW_DTRDSR && peer_set_ready_n);
    assign ttk.restart = (ts == UBM_S_LEAD);
    always_comb begin
        next_ts = ts;
        next_tsh = tsh;
        next_tcnt = tcnt;
        next_tbit = tbit;
        next_tact = tact;
        tx_done = 1'b0;
        unique case (ts)
            UBM_S_IDLE: if (tx_full && tx_allowed) begin
                next_ts = UBM_S_LEAD;
                next_tsh = tx_hold;
                next_tact = 1'b1;
            end
            UBM_S_LEAD: begin
                next_ts = UBM_S_START;
                next_tbit = 1'b0;
            end
            UBM_S_START: if (ttk.tick) begin
                next_ts = UBM_S_DATA;
                next_tbit = tsh[0];
                next_tcnt = 3'h0;
            end
            UBM_S_DATA: if (ttk.tick) begin
                next_tcnt = tcnt + 3'h1;
                next_tsh = {1'b0, tsh[7:1]};
                next_tbit = tsh[1];
                if (tcnt == (bits8 ? 3'h7 : 3'h6)) begin
                    next_ts = par_on ? UBM_S_PAR : UBM_S_STOP;
                    next_tbit = par_on ? ubm_parity(tframe, bits8, par_mode)
                                       : 1'b1;
                    next_tcnt = 3'h0;
                end
            end
            UBM_S_PAR: if (ttk.tick) begin
                next_ts = UBM_S_STOP;
                next_tbit = 1'b1;
                next_tcnt = 3'h0;
            end
            UBM_S_STOP: if (ttk.tick) begin
                next_tcnt = tcnt + 3'h1;
                if (tcnt == {2'b00, stop2}) begin
                    next_ts = UBM_S_IDLE;
                    next_tact = 1'b0;
                    tx_done = 1'b1;
                end
            end
            default: next_ts = UBM_S_IDLE;
        endcase
    end
    // Parity needs the original byte, kept apart from the shifter
    assign next_tframe = (ts == UBM_S_IDLE) ? tx_hold : tframe;

    // ==========================================
    // Receiver: start found on low, sampled at bit centres
    assign rtk.restart = (rs == UBM_S_IDLE);
    always_comb begin
        next_rs = rs;
        next_rsh = rsh;
        next_rcnt = rcnt;
        next_rpar = rpar;
        rx_done = 1'b0;
        rx_perr = 1'b0;
        unique case (rs)
            UBM_S_IDLE: if (!rxd && uart_on && ctrl[UBM_CTRL_EN]) next_rs = UBM_S_START;
            UBM_S_START: if (rtk.half) begin
                next_rs = rxd ? UBM_S_IDLE : UBM_S_DATA;
                next_rcnt = 3'h0;
            end
            UBM_S_DATA: if (rtk.half) begin
                next_rsh = {rxd, rsh[7:1]};
                next_rcnt = rcnt + 3'h1;
                if (rcnt == (bits8 ? 3'h7 : 3'h6)) next_rs = par_on ? UBM_S_PAR : UBM_S_STOP;
            end
            UBM_S_PAR: if (rtk.half) begin
                next_rpar = rxd;
                next_rs = UBM_S_STOP;
            end
            UBM_S_STOP: if (rtk.half) begin
                next_rs = UBM_S_IDLE;
                rx_done = 1'b1;
                rx_perr = par_on && (rpar != ubm_parity(bits8 ? rsh : {1'b0, rsh[7:1]},
                                                        bits8, par_mode));
            end
            default: next_rs = UBM_S_IDLE;
        endcase
    end
    assign rx_busy = (rs != UBM_S_IDLE);

    // ==========================================
    // Pins
    assign txd = tbit;
    assign tx_active = tact;
    // Not ready while the strap or UBM_CTRL_EN disables the port, or while a character is arriving with the holding register already full
    assign receive_ready_n = !(uart_on && ctrl[UBM_CTRL_EN] && !(rx_full && rx_busy));
    assign terminal_ready_n = !(uart_on && ctrl[UBM_CTRL_TERM]);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl <= UBM_CTRL_RESET;
            baud <= UBM_BAUD_RESET;
            irq_st <= '0;
            irq_mask <= '0;
            tx_hold <= 8'h00;
            rx_hold <= 8'h00;
            tx_full <= 1'b0;
            rx_full <= 1'b0;
            reg_rdata <= 32'h00000000;
            uart_on <= 1'b0;
            cfg_done <= 1'b0;
            ring_q <= 1'b0;
            ts <= UBM_S_IDLE;
            rs <= UBM_S_IDLE;
            tsh <= 8'h00;
            rsh <= 8'h00;
            tcnt <= 3'h0;
            rcnt <= 3'h0;
            tbit <= 1'b1;
            tact <= 1'b0;
            rpar <= 1'b0;
            tframe <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            baud <= next_baud;
            irq_st <= next_irq_st;
            irq_mask <= next_irq_mask;
            tx_hold <= next_tx_hold;
            rx_hold <= next_rx_hold;
            tx_full <= next_tx_full;
            rx_full <= next_rx_full;
            reg_rdata <= next_rdata;
            uart_on <= next_uart_on;
            cfg_done <= next_cfg_done;
            ring_q <= next_ring_q;
            ts <= next_ts;
            rs <= next_rs;
            tsh <= next_tsh;
            rsh <= next_rsh;
            tcnt <= next_tcnt;
            rcnt <= next_rcnt;
            tbit <= next_tbit;
            tact <= next_tact;
            rpar <= next_rpar;
            tframe <= next_tframe;
        end
    end

    // ==========================================
    // Checks
    a_lead_start: assert property (@(posedge core_clk) disable iff (rst)
        $rose(tx_active) |-> txd ##1 !txd) else $error("tx_active not one cycle ahead");
    a_active_stop: assert property (@(posedge core_clk) disable iff (rst)
        $fell(tx_active) |-> txd && $past(txd)) else $error("tx_active fell off stop");
    a_cts_block: assert property (@(posedge core_clk) disable iff (rst)
        (flow == UBM_FLOW_RTSCTS && peer_ready_n && ts == UBM_S_IDLE) |=> ts == UBM_S_IDLE)
        else $error("frame began with peer not ready");
    a_dsr_block: assert property (@(posedge core_clk) disable iff (rst)
        (flow == UBM_FLOW_DTRDSR && peer_set_ready_n && ts == UBM_S_IDLE) |=> !$rose(tact))
        else $error("frame began without connection");
    a_div_range: assert property (@(posedge core_clk) disable iff (rst)
        baud[18:3] >= UBM_DIV_MIN && baud[18:3] <= UBM_DIV_MAX)
        else $error("divisor outside legal window");
    a_unconf_quiet: assert property (@(posedge core_clk) disable iff (rst)
        !cfg_done |-> txd && !tx_active) else $error("sent before configuration");
    a_rts_full: assert property (@(posedge core_clk) disable iff (rst)
        (rx_full && rx_busy) |-> receive_ready_n) else $error("ready while both full");
    a_dtr_term: assert property (@(posedge core_clk) disable iff (rst)
        $rose(ctrl[UBM_CTRL_TERM]) && uart_on |-> !terminal_ready_n)
        else $error("terminal ready not driven");
    a_ring_irq: assert property (@(posedge core_clk) disable iff (rst)
        $rose(ring_indicate) |=> irq_st[UBM_IRQ_RING]) else $error("ring lost");
endmodule : ubm_uart
`default_nettype wire

// ### inc/ubm_pkg.sv
// Purpose: Shared constants and types for the UART baud and modem-line block
// Assumes: One 100 MHz core clock, synchronous active-high reset
// Notes: Register offsets are word addresses on the plain register port
package ubm_pkg;
    // ==========================================
    // Register map
    localparam logic [3:0] UBM_REG_CTRL = 4'h0;
    localparam logic [3:0] UBM_REG_BAUD = 4'h1;
    localparam logic [3:0] UBM_REG_STAT = 4'h2;
    localparam logic [3:0] UBM_REG_TXD = 4'h3;
    localparam logic [3:0] UBM_REG_RXD = 4'h4;
    localparam logic [3:0] UBM_REG_IRQ = 4'h5;
    localparam logic [3:0] UBM_REG_MASK = 4'h6;
    // ==========================================
    // Control fields
    localparam int UBM_CTRL_EN = 0;
    localparam int UBM_CTRL_BITS8 = 1;
    localparam int UBM_CTRL_PAR_LSB = 2;
    localparam int UBM_CTRL_STOP2 = 5;
    localparam int UBM_CTRL_FLOW_LSB = 6;
    localparam int UBM_CTRL_TERM = 8;
    localparam logic [8:0] UBM_CTRL_RESET = 9'h000;
    // ==========================================
    // Baud divisor: integer part and eighths
    localparam int UBM_FRAC_W = 3;
    localparam int UBM_INT_W = 16;
    localparam logic [15:0] UBM_DIV_MIN = 16'h0004;
    localparam logic [15:0] UBM_DIV_MAX = 16'h9C40;
    localparam logic [18:0] UBM_BAUD_RESET = 19'h00020;
    localparam real UBM_BAUD_MIN_KBAUD = 1.2;
    localparam real UBM_BAUD_MAX_MBAUD = 12.0;
    // ==========================================
    // Interrupt bits
    localparam int UBM_IRQ_TXDONE = 0;
    localparam int UBM_IRQ_RXFULL = 1;
    localparam int UBM_IRQ_PERR = 2;
    localparam int UBM_IRQ_RING = 3;
    localparam int UBM_IRQ_W = 4;
    // ==========================================
    // Enumerations
    typedef enum logic [2:0] {
        UBM_PAR_NONE = 3'h0,
        UBM_PAR_ODD = 3'h1,
        UBM_PAR_EVEN = 3'h2,
        UBM_PAR_HIGH = 3'h3,
        UBM_PAR_LOW = 3'h4
    } ubm_par_e;
    typedef enum logic [1:0] {
        UBM_FLOW_NONE = 2'h0,
        UBM_FLOW_RTSCTS = 2'h1,
        UBM_FLOW_DTRDSR = 2'h2
    } ubm_flow_e;
    typedef enum logic [2:0] {
        UBM_S_IDLE = 3'h0,
        UBM_S_LEAD = 3'h1,
        UBM_S_START = 3'h2,
        UBM_S_DATA = 3'h3,
        UBM_S_PAR = 3'h4,
        UBM_S_STOP = 3'h5
    } ubm_state_e;

    // Parity bit for a frame; data above bit 6 is masked when 7 bits
    function automatic logic ubm_parity(input logic [7:0] d, input logic bits8,
                                        input logic [2:0] mode);
        logic ones;
        ones = ^{d[7] & bits8, d[6:0]};
        unique case (mode)
            UBM_PAR_ODD: ubm_parity = ~ones;
            UBM_PAR_EVEN: ubm_parity = ones;
            UBM_PAR_HIGH: ubm_parity = 1'b1;
            default: ubm_parity = 1'b0;
        endcase
    endfunction : ubm_parity
endpackage : ubm_pkg

// ### inc/ubm_tick_if.sv
// Purpose: Bit-timing link between the top and its baud generators
// Assumes: Single clock domain
// Notes: restart realigns a generator at a frame edge
`timescale 1ns/100ps
`default_nettype none
interface ubm_tick_if;
    logic restart;
    logic half;
    logic tick;
    modport gen (input restart, output half, output tick);
    modport user (output restart, input half, input tick);
endinterface : ubm_tick_if
`default_nettype wire

// ### rtl/ubm_baud_gen.sv
// Purpose: Fractional baud tick generator, divisor in eighths
// Assumes: Divisor already clamped to the legal range
// Notes: tick marks a bit boundary, half marks a bit centre
`timescale 1ns/100ps
`default_nettype none
module ubm_baud_gen (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Divisor, integer and eighths
    input wire logic [ubm_pkg::UBM_INT_W-1:0] div_int,
    input wire logic [ubm_pkg::UBM_FRAC_W-1:0] div_frac,
    // Tick link
    ubm_tick_if.gen tk
);
    import ubm_pkg::*;
    logic [UBM_INT_W-1:0] cnt, next_cnt;
    logic [UBM_FRAC_W-1:0] acc, next_acc;
    logic [UBM_INT_W-1:0] period;
    logic [UBM_FRAC_W:0] sum;

    // ==========================================
    // Period stretch by one cycle when eighths overflow
    always_comb begin
        sum = {1'b0, acc} + {1'b0, div_frac};
        period = div_int + {{(UBM_INT_W-1){1'b0}}, sum[UBM_FRAC_W]};
        next_cnt = cnt + 16'h0001;
        next_acc = acc;
        if (tk.restart) begin
            next_cnt = 16'h0001;
            next_acc = '0;
        end else if (cnt >= period) begin
            next_cnt = 16'h0001;
            next_acc = sum[UBM_FRAC_W-1:0];
        end
    end
    assign tk.tick = !tk.restart && (cnt >= period);
    assign tk.half = !tk.restart && (cnt == {1'b0, div_int[UBM_INT_W-1:1]});

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt <= 16'h0001;
            acc <= '0;
        end else begin
            cnt <= next_cnt;
            acc <= next_acc;
        end
    end

    // Minimum spacing: ticks never closer than four cycles, the smallest divisor
    a_tick_spacing: assert property (@(posedge core_clk) disable iff (rst)
        tk.tick |=> !tk.tick [*3]) else $error("baud ticks closer than four cycles");
endmodule : ubm_baud_gen
`default_nettype wire

// ### test/ubm_peer.sv
// Purpose: Serial equipment model on the far side of the UART pins
// Assumes: Bit period in core clocks set by the bench through div
// Notes: Samples the nbits bits after the start bit at their centres, stop bits unsampled; drives rxd idle high
`timescale 1ns/100ps
`default_nettype none
module ubm_peer (
    // Clock and serial line
    input wire logic core_clk,
    input wire logic txd,
    output logic rxd,
    // Modem lines toward the device
    output logic peer_ready_n,
    output logic peer_set_ready_n,
    output logic carrier_detect,
    output logic ring_indicate
);
    int div = 8;
    int nbits = 8;
    logic [9:0] got;
    initial begin
        rxd = 1'b1;
        peer_ready_n = 1'b0;
        peer_set_ready_n = 1'b0;
        carrier_detect = 1'b1;
        ring_indicate = 1'b0;
    end
    // ==========================================
    // Receiver: start edge, then bit centres
    always begin
        @(negedge txd);
        repeat (div / 2) @(posedge core_clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (div) @(posedge core_clk);
            #1 got[i] = txd;
        end
        repeat (div) @(posedge core_clk);
    end
    // ==========================================
    // Transmitter: 8N1 frame, low bit first
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            rxd <= f[i];
            repeat (div - 1) @(posedge core_clk);
        end
    endtask : send
endmodule : ubm_peer
`default_nettype wire

// ### test/ubm_uart_tb.sv
// Purpose: Self-checking bench for the UART baud and modem-line block
// Assumes: Straps enable the serial port; peer model at the pins
// Notes: Frame lengths measured on tx_active in core clocks
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module ubm_uart_tb;
    import ubm_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq, pin0 = 1'b0, pin1 = 1'b1;
    logic rxd, txd, tx_active, receive_ready_n, terminal_ready_n;
    logic peer_ready_n, peer_set_ready_n, carrier_detect, ring_indicate;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] v;
    int len;
    logic p;
    initial forever #5 core_clk = ~core_clk;
    ubm_uart dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .interface_cfg_pin0(pin0), .interface_cfg_pin1(pin1), .rxd(rxd),
        .txd(txd), .tx_active(tx_active), .receive_ready_n(receive_ready_n),
        .peer_ready_n(peer_ready_n), .terminal_ready_n(terminal_ready_n),
        .peer_set_ready_n(peer_set_ready_n), .carrier_detect(carrier_detect),
        .ring_indicate(ring_indicate));
    ubm_peer peer (.core_clk(core_clk), .txd(txd), .rxd(rxd), .peer_ready_n(peer_ready_n),
        .peer_set_ready_n(peer_set_ready_n), .carrier_detect(carrier_detect),
        .ring_indicate(ring_indicate));
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Cycles tx_active stays high for one character
    task automatic frame(input logic [7:0] d, output int n);
        int w;
        wr(UBM_REG_TXD, {24'h0, d});
        w = 0;
        while (tx_active !== 1'b1 && w < 300) begin
            @(posedge core_clk);
            #1 w++;
        end
        n = 0;
        while (tx_active === 1'b1 && n < 2000) begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask : frame
    task automatic test_done;
        $display("comparisons=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            test_done;
        end
    end
    // ==========================================
    // Scenarios
    task automatic t_reset;
        #1;
        `CHK(txd, 1'b1)
        `CHK(tx_active, 1'b0)
        `CHK({irq, receive_ready_n, terminal_ready_n}, 3'b011)
        rd(UBM_REG_CTRL, v);
        `CHK(v, 32'h0)
        rd(UBM_REG_BAUD, v);
        `CHK(v, 32'h20)
        rd(4'hF, v);
        `CHK(v, 32'h0)
        $display("reset test done");
    endtask : t_reset
    task automatic t_parity;
        wr(UBM_REG_BAUD, 32'h40);
        for (int m = 0; m < 5; m++) begin
            wr(UBM_REG_CTRL, 32'h101 | (m << 2) | ((m == 4) ? 32'h20 : 32'h0));
            peer.nbits = 7 + (m != 0);
            frame(8'h5B, len);
            p = (m == 1) ? ~^7'h5B : (m == 2) ? ^7'h5B : (m == 3);
            `CHK(len, 1 + (2 + peer.nbits + (m == 4)) * 8)
            `CHK(peer.got[6:0], 7'h5B)
            if (m != 0) `CHK(peer.got[7], p)
            `CHK(terminal_ready_n, 1'b0)
        end
        $display("parity test done");
    endtask : t_parity
    task automatic t_divisor;
        wr(UBM_REG_CTRL, 32'h3);
        peer.nbits = 8;
        wr(UBM_REG_BAUD, 32'h44);
        frame(8'h0F, len);
        `CHK(len >= 85 && len <= 87, 1'b1)
        peer.div = 4;
        wr(UBM_REG_BAUD, 32'h08);
        frame(8'hC3, len);
        `CHK(len, 41)
        `CHK(peer.got[7:0], 8'hC3)
        wr(UBM_REG_BAUD, 32'h7FFFF);
        rd(UBM_REG_BAUD, v);
        `CHK(v, 32'h4E207)
        peer.div = 8;
        wr(UBM_REG_BAUD, 32'h40);
        $display("divisor test done");
    endtask : t_divisor
    task automatic t_flow;
        for (int f = 1; f < 3; f++) begin
            wr(UBM_REG_CTRL, 32'h3 | (f << 6));
            if (f == 1) peer.peer_ready_n <= 1'b1;
            else peer.peer_set_ready_n <= 1'b1;
            wr(UBM_REG_TXD, (f == 1) ? 32'h55 : 32'hA9);
            len = 0;
            repeat (40) begin
                @(posedge core_clk);
                len += (tx_active !== 1'b0) || (txd !== 1'b1);
            end
            `CHK(len, 0)
            peer.peer_ready_n <= 1'b0;
            peer.peer_set_ready_n <= 1'b0;
            len = 0;
            repeat (100) begin
                @(posedge core_clk);
                #1 len += (tx_active === 1'b1);
            end
            `CHK(len, 81)
            `CHK(peer.got[7:0], (f == 1) ? 8'h55 : 8'hA9)
        end
        $display("flow test done");
    endtask : t_flow
    task automatic t_rx;
        wr(UBM_REG_IRQ, 32'hF);
        wr(UBM_REG_MASK, 32'h2);
        #1;
        `CHK({irq, receive_ready_n}, 2'b00)
        peer.send(8'hA6);
        repeat (20) @(posedge core_clk);
        `CHK(irq, 1'b1)
        fork
            peer.send(8'h3C);
            begin
                repeat (40) @(posedge core_clk);
                #1 `CHK(receive_ready_n, 1'b1)
            end
        join
        repeat (20) @(posedge core_clk);
        rd(UBM_REG_RXD, v);
        `CHK(v[7:0], 8'hA6)
        wr(UBM_REG_IRQ, 32'h2);
        #1 `CHK(irq, 1'b0)
        $display("receive test done");
    endtask : t_rx
    task automatic t_lines;
        wr(UBM_REG_MASK, 32'h8);
        peer.ring_indicate <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1 `CHK(irq, 1'b1)
        rd(UBM_REG_STAT, v);
        `CHK(v[5:4], 2'b11)
        wr(UBM_REG_MASK, 32'h0);
        #1 `CHK(irq, 1'b0)
        wr(UBM_REG_IRQ, 32'hF);
        wr(UBM_REG_MASK, 32'h8);
        #1 `CHK(irq, 1'b0)
        wr(UBM_REG_CTRL, 32'h183);
        #1 `CHK(terminal_ready_n, 1'b0)
        pin1 <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 `CHK({terminal_ready_n, receive_ready_n}, 2'b11)
        $display("modem line test done");
    endtask : t_lines
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset;
        t_parity;
        t_divisor;
        t_flow;
        t_rx;
        t_lines;
        test_done;
    end
endmodule : ubm_uart_tb
`default_nettype wire
